/* hw/waveform_mask_judge.v */
// What this block does
// R1 - judge every new record against registered mask
// R2 - pass drives output low, fail high
// R3 - user picks fail inside or outside mask
// R4 - only samples between time bars count
// R5 - judged channel: one of four or any
// R6 - quantifier and polarity give four conditions
// R7 - edit source is on-screen reference channel record
// R8 - edited mask takes effect only at edit end
// R9 - vertical: clockwise up, counter-clockwise down
// R10 - horizontal: clockwise right, counter-clockwise left
// R11 - region between boundaries is the failing domain
// R12 - range edit: keys pick bar, knob moves
// R13 - output held until next judgement ends
// R14 - bare cycle about 100ms, actions add time
// R15 - hold freezes failing record until run key
// R16 - save stores record, then resumes automatically
// R17 - print takes 50s, ignores input, resumes
// R18 - service request raised on each failure while the service-request action is selected
// R19 - no action: only the output reports failure
// R20 - output stays valid while judging is on
// R21 - judgement switch on runs, off returns normal
// R22 - printing never stops judging, only switch does
// R23 - mask held as per-index upper/lower limits
// R24 - any-channel fails if one shown channel fails
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "mask_judge_regs.vh"

module waveform_mask_judge #(
  parameter [31:0] CYCLE_CNT = `CYCLE_CNT,
  parameter [63:0] PRINT_CNT = `PRINT_CNT
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output wire [31:0] rdata,
  input wire rec_start,
  input wire rec_end,
  input wire smp_valid,
  input wire [8:0] smp_idx,
  input wire [7:0] channel_one_smp,
  input wire [7:0] channel_two_smp,
  input wire [7:0] channel_three_smp,
  input wire [7:0] channel_four_smp,
  input wire [3:0] ch_shown,
  input wire adjust_knob_cw,
  input wire adjust_knob_ccw,
  input wire key_up,
  input wire key_down,
  input wire key_left,
  input wire key_right,
  input wire run_key,
  input wire save_done,
  output wire pass_fail_output_o,
  output wire pass_fail_output_oe,
  output wire save_req,
  output wire print_busy,
  output wire srq_pulse,
  output wire hold_freeze,
  output wire judging
);

  localparam [2:0] S_OFF = 3'd0;
  localparam [2:0] S_WAIT = 3'd1;
  localparam [2:0] S_ACQ = 3'd2;
  localparam [2:0] S_VERD = 3'd3;
  localparam [2:0] S_GAP = 3'd4;
  localparam [2:0] S_HOLD = 3'd5;
  localparam [2:0] S_SAVE = 3'd6;
  localparam [2:0] S_PRINT = 3'd7;

  localparam [1:0] E_IDLE = 2'd0;
  localparam [1:0] E_LOAD = 2'd1;
  localparam [1:0] E_EDIT = 2'd2;
  localparam [1:0] E_COMMIT = 2'd3;

  reg [8:0] ctrl_q;
  reg [15:0] edit_q;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [1:0] e_st_q;
  reg [8:0] e_cnt_q;
  reg e_range_q;
  reg vert_q;
  reg bar_right_q;
  reg signed [8:0] voff_q;
  reg signed [8:0] hoff_q;
  reg [8:0] left_q;
  reg [8:0] right_q;
  reg [8:0] eleft_q;
  reg [8:0] eright_q;
  reg [31:0] cyc_q;
  reg [35:0] prn_q;
  reg pf_fail_q;
  reg save_req_q;
  reg srq_q;
  reg [15:0] judged_q;
  reg [15:0] fails_q;
  reg [31:0] rdata_q;

  reg [7:0] scr_mem [0:4*`REC_LEN-1];
  reg [7:0] ref_mem [0:`REC_LEN-1];
  reg [7:0] up_mem [0:`REC_LEN-1];
  reg [7:0] lo_mem [0:`REC_LEN-1];

  wire judge_on = ctrl_q[`CTRL_ON];
  wire all_sel = ctrl_q[`CTRL_ALL];
  wire fail_in = ctrl_q[`CTRL_IN];
  wire [2:0] ch_sel = ctrl_q[`CTRL_CH_HI:`CTRL_CH_LO];
  wire [2:0] action = ctrl_q[`CTRL_ACT_HI:`CTRL_ACT_LO];
  wire [1:0] src_ch = edit_q[`EDIT_SRC_HI:`EDIT_SRC_LO];
  wire edit_go = edit_q[`EDIT_GO];
  wire [7:0] band = edit_q[`EDIT_BAND_HI:`EDIT_BAND_LO];

  wire [31:0] smp_all = {channel_four_smp, channel_three_smp,
                         channel_two_smp, channel_one_smp};

  // the screen copy stays still while a failing record is shown or printed
  wire frozen = (st_q == S_HOLD) || (st_q == S_PRINT); // R15 R17
  wire scr_we = smp_valid && !frozen;

  // judgement waits while a new mask is being written in
  wire accept = (st_q == S_WAIT) && rec_start && (e_st_q != E_COMMIT); // R1
  wire in_win = (smp_idx >= left_q) && (smp_idx <= right_q); // R4
  wire smp_en = (st_q == S_ACQ) && smp_valid && in_win; // R4
  wire [7:0] up_v = up_mem[smp_idx];
  wire [7:0] lo_v = lo_mem[smp_idx];
  wire [3:0] fail_ch;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_ch
      wire [7:0] s = smp_all[g*8 +: 8];
      chan_judge u_judge (
        .clk(clk),
        .arst_n(arst_n),
        .clr(accept),
        .smp_en(smp_en),
        .in_mask((s >= lo_v) && (s <= up_v)), // R23 R11
        .all_sel(all_sel),
        .fail_in(fail_in),
        .fail(fail_ch[g])
      );
    end
  endgenerate

  reg fail_now;
  always @* begin
    case (ch_sel)
      3'd0: fail_now = fail_ch[0]; // R5
      3'd1: fail_now = fail_ch[1]; // R5
      3'd2: fail_now = fail_ch[2]; // R5
      3'd3: fail_now = fail_ch[3]; // R5
      default: fail_now = |(fail_ch & ch_shown); // R24
    endcase
  end

  // mask build: shift the reference by the knob offsets, widen by the band
  function [7:0] clamp8;
    input [10:0] v;
    begin
      if (v[10])
        clamp8 = 8'h00;
      else if (v[9] | v[8])
        clamp8 = 8'hff;
      else
        clamp8 = v[7:0];
    end
  endfunction

  wire [10:0] src_j = {2'b00, e_cnt_q} - {{2{hoff_q[8]}}, hoff_q}; // R10
  wire j_ok = ~src_j[10] & ~src_j[9];
  wire [7:0] ref_v = ref_mem[src_j[8:0]];
  wire [10:0] voff_x = {{2{voff_q[8]}}, voff_q};
  wire [10:0] up_sum = {3'b000, ref_v} + {3'b000, band} + voff_x; // R9
  wire [10:0] lo_sum = {3'b000, ref_v} - {3'b000, band} + voff_x; // R9
  // outside the shifted reference the domain is empty, so samples are out
  wire [7:0] up_calc = j_ok ? clamp8(up_sum) : 8'h00;
  wire [7:0] lo_calc = j_ok ? clamp8(lo_sum) : 8'hff;

  // memories carry no reset; their contents are don't-care until written
  integer k;
  always @(posedge clk) begin
    for (k = 0; k < 4; k = k + 1) begin
      if (scr_we)
        scr_mem[k*`REC_LEN + smp_idx] <= smp_all[k*8 +: 8];
    end
    if (e_st_q == E_LOAD)
      ref_mem[e_cnt_q] <= scr_mem[{src_ch, e_cnt_q}]; // R7
    if (e_st_q == E_COMMIT) begin
      up_mem[e_cnt_q] <= up_calc; // R23 R8
      lo_mem[e_cnt_q] <= lo_calc; // R23 R8
    end
  end

  // edit sequencer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      e_st_q <= E_IDLE;
      e_cnt_q <= 9'h000;
      e_range_q <= 1'b0;
      vert_q <= 1'b1;
      bar_right_q <= 1'b0;
      voff_q <= 9'sd0;
      hoff_q <= 9'sd0;
      left_q <= `LEFT_RST;
      right_q <= `RIGHT_RST;
      eleft_q <= `LEFT_RST;
      eright_q <= `RIGHT_RST;
    end else begin
      if (key_up | key_down)
        vert_q <= 1'b1;
      else if (key_left | key_right)
        vert_q <= 1'b0;
      if (key_left)
        bar_right_q <= 1'b0; // R12
      else if (key_right)
        bar_right_q <= 1'b1; // R12
      case (e_st_q)
        E_IDLE: begin
          if (edit_go) begin
            e_range_q <= edit_q[`EDIT_RANGE];
            eleft_q <= left_q;
            eright_q <= right_q;
            e_cnt_q <= 9'h000;
            voff_q <= 9'sd0;
            hoff_q <= 9'sd0;
            e_st_q <= edit_q[`EDIT_RANGE] ? E_EDIT : E_LOAD; // R7
          end
        end
        E_LOAD: begin
          e_cnt_q <= e_cnt_q + 9'h001;
          if (e_cnt_q == 9'h1ff)
            e_st_q <= E_EDIT;
        end
        E_EDIT: begin
          if (!edit_go) begin
            if (e_range_q) begin
              left_q <= eleft_q; // R8
              right_q <= eright_q; // R8
              e_st_q <= E_IDLE;
            end else begin
              e_cnt_q <= 9'h000;
              e_st_q <= E_COMMIT; // R8
            end
          end else if (e_range_q) begin
            if (!bar_right_q && adjust_knob_cw && eleft_q < eright_q)
              eleft_q <= eleft_q + 9'h001; // R12
            else if (!bar_right_q && adjust_knob_ccw && eleft_q != 9'h000)
              eleft_q <= eleft_q - 9'h001; // R12
            else if (bar_right_q && adjust_knob_cw && eright_q != 9'h1ff)
              eright_q <= eright_q + 9'h001; // R12
            else if (bar_right_q && adjust_knob_ccw && eright_q > eleft_q)
              eright_q <= eright_q - 9'h001; // R12
          end else if (vert_q) begin
            if (adjust_knob_cw)
              voff_q <= voff_q + 9'sd1; // R9
            else if (adjust_knob_ccw)
              voff_q <= voff_q - 9'sd1; // R9
          end else begin
            if (adjust_knob_cw)
              hoff_q <= hoff_q + 9'sd1; // R10
            else if (adjust_knob_ccw)
              hoff_q <= hoff_q - 9'sd1; // R10
          end
        end
        E_COMMIT: begin
          e_cnt_q <= e_cnt_q + 9'h001;
          if (e_cnt_q == 9'h1ff)
            e_st_q <= E_IDLE;
        end
        default: e_st_q <= E_IDLE;
      endcase
    end
  end

  // judgement sequencer
  wire cyc_done = (cyc_q >= CYCLE_CNT - 32'd1);
  wire prn_done = ({28'h0000000, prn_q} >= PRINT_CNT - 64'd1);

  always @* begin
    st_d = st_q;
    case (st_q)
      S_OFF: if (judge_on) st_d = S_WAIT; // R21
      S_WAIT: if (accept) st_d = S_ACQ; // R1
      S_ACQ: if (rec_end) st_d = S_VERD;
      S_VERD: begin
        if (!fail_now)
          st_d = S_GAP;
        else begin
          case (action)
            `ACT_HOLD: st_d = S_HOLD; // R15
            `ACT_SAVE: st_d = S_SAVE; // R16
            `ACT_PRINT: st_d = S_PRINT; // R17
            default: st_d = S_GAP; // R18 R19
          endcase
        end
      end
      S_GAP: if (cyc_done) st_d = S_WAIT; // R14
      S_HOLD: if (run_key) st_d = S_WAIT; // R15
      S_SAVE: if (save_done) st_d = S_GAP; // R16
      S_PRINT: if (prn_done) st_d = S_GAP; // R17 R22
      default: st_d = S_OFF;
    endcase
    if (!judge_on)
      st_d = S_OFF; // R21 R22
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_OFF;
      cyc_q <= 32'h00000000;
      prn_q <= 36'h000000000;
      pf_fail_q <= 1'b0;
      save_req_q <= 1'b0;
      srq_q <= 1'b0;
      judged_q <= 16'h0000;
      fails_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      save_req_q <= 1'b0;
      srq_q <= 1'b0;
      // cycle timer pauses inside actions so their time adds on top
      if (st_q == S_OFF || (st_q == S_GAP && cyc_done))
        cyc_q <= 32'h00000000; // R14
      else if (st_q == S_WAIT || st_q == S_ACQ || st_q == S_VERD || st_q == S_GAP)
        cyc_q <= cyc_q + 32'h00000001; // R14
      if (st_q == S_PRINT)
        prn_q <= prn_q + 36'h000000001; // R17
      else
        prn_q <= 36'h000000000;
      if (st_q == S_OFF)
        pf_fail_q <= 1'b0;
      else if (st_q == S_VERD) begin
        pf_fail_q <= fail_now; // R13 R20
        judged_q <= judged_q + 16'h0001;
        if (fail_now) begin
          fails_q <= fails_q + 16'h0001;
          save_req_q <= (action == `ACT_SAVE); // R16
          srq_q <= (action == `ACT_SRQ); // R18
        end
      end
    end
  end

  // register port
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CTRL_RST;
      edit_q <= `EDIT_RST;
      rdata_q <= 32'h00000000;
    end else begin
      if (wr_en && addr == `ADDR_CTRL)
        ctrl_q <= wdata[8:0];
      if (wr_en && addr == `ADDR_EDIT)
        edit_q <= wdata[15:0];
      if (rd_en) begin
        case (addr)
          `ADDR_CTRL: rdata_q <= {23'h000000, ctrl_q};
          `ADDR_EDIT: rdata_q <= {16'h0000, edit_q};
          `ADDR_STAT: rdata_q <= {23'h000000, e_st_q, st_q, e_range_q,
                                  vert_q, bar_right_q, pf_fail_q};
          `ADDR_RANGE: rdata_q <= {7'h00, right_q, 7'h00, left_q};
          `ADDR_OFFS: rdata_q <= {7'h00, hoff_q, 7'h00, voff_q};
          `ADDR_COUNT: rdata_q <= {fails_q, judged_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end else
        rdata_q <= 32'h00000000;
    end
  end

  assign rdata = rdata_q;
  // open collector: pulling low means pass, released (pulled high) means fail
  assign pass_fail_output_o = 1'b0; // R2
  assign pass_fail_output_oe = ~pf_fail_q; // R2 R13
  assign save_req = save_req_q;
  assign srq_pulse = srq_q;
  assign print_busy = (st_q == S_PRINT);
  assign hold_freeze = (st_q == S_HOLD);
  assign judging = (st_q != S_OFF);

endmodule

/* hw/mask_judge_regs.vh */
`ifndef MASK_JUDGE_REGS_VH
`define MASK_JUDGE_REGS_VH

// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_EDIT 8'h04
`define ADDR_STAT 8'h08
`define ADDR_RANGE 8'h0c
`define ADDR_OFFS 8'h10
`define ADDR_COUNT 8'h14

// control register fields
`define CTRL_ON 0
`define CTRL_ALL 1
`define CTRL_IN 2
`define CTRL_CH_LO 3
`define CTRL_CH_HI 5
`define CTRL_ACT_LO 6
`define CTRL_ACT_HI 8
`define CTRL_RST 9'h000

// edit register fields
`define EDIT_RANGE 0
`define EDIT_SRC_LO 1
`define EDIT_SRC_HI 2
`define EDIT_GO 3
`define EDIT_BAND_LO 8
`define EDIT_BAND_HI 15
`define EDIT_RST 16'h1000

// channel selector and post-fail actions
`define CH_ANY 3'h4
`define ACT_NONE 3'h0
`define ACT_HOLD 3'h1
`define ACT_SAVE 3'h2
`define ACT_PRINT 3'h3
`define ACT_SRQ 3'h4

// record geometry and bar reset positions
`define REC_LEN 512
`define LEFT_RST 9'h000
`define RIGHT_RST 9'h1ff

// timing
`define CLK_KHZ 250000
`define CYCLE_MS 100
`define CYCLE_CNT (`CYCLE_MS * `CLK_KHZ)
`define PRINT_S 50
`define PRINT_CNT (`PRINT_S * 64'd1000 * `CLK_KHZ)

`endif

/* hw/chan_judge.v */
`timescale 1ns/1ps
`include "mask_judge_regs.vh"

module chan_judge (
  input wire clk,
  input wire arst_n,
  input wire clr,
  input wire smp_en,
  input wire in_mask,
  input wire all_sel,
  input wire fail_in,
  output wire fail
);

  reg any_in_q;
  reg any_out_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      any_in_q <= 1'b0;
      any_out_q <= 1'b0;
    end else if (clr) begin
      any_in_q <= 1'b0;
      any_out_q <= 1'b0;
    end else if (smp_en) begin
      any_in_q <= any_in_q | in_mask;
      any_out_q <= any_out_q | ~in_mask;
    end
  end

  // an empty window never fails under the all quantifier
  wire seen = any_in_q | any_out_q;
  assign fail = all_sel ? (fail_in ? (seen & ~any_out_q) : (seen & ~any_in_q)) // R6 R3
                        : (fail_in ? any_in_q : any_out_q); // R6 R3

endmodule

/* bench/waveform_mask_judge_props.sv */
`timescale 1ns/1ps
module waveform_mask_judge_props #(
  parameter [63:0] PRINT_CNT = 64'd20
) (
  input wire clk,
  input wire arst_n,
  input wire rec_end,
  input wire run_key,
  input wire wr_en,
  input wire pass_fail_output_o,
  input wire pass_fail_output_oe,
  input wire save_req,
  input wire print_busy,
  input wire srq_pulse,
  input wire hold_freeze,
  input wire judging
);
  logic [63:0] pcnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // too long to unroll, so the printer wait is counted here
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) pcnt_q <= 64'h0;
    else pcnt_q <= print_busy ? pcnt_q + 64'h1 : 64'h0;
  end
  chk_oc_low: assert property (!pass_fail_output_o)
    else $error("pin data not low");
  chk_off_pass: assert property (
    !judging && !$past(judging) |-> pass_fail_output_oe)
    else $error("no pass while off");
  chk_level_held: assert property (
    $changed(pass_fail_output_oe) |-> $past(rec_end, 2) || !judging || !$past(judging))
    else $error("level changed early");
  chk_srq_fail: assert property (
    srq_pulse |-> $past(rec_end, 2) && !pass_fail_output_oe ##1 !srq_pulse)
    else $error("bad service request");
  chk_save_fail: assert property (
    save_req |-> !pass_fail_output_oe ##1 !save_req)
    else $error("bad store request");
  chk_print_len: assert property (
    $fell(print_busy) && judging |-> pcnt_q == PRINT_CNT)
    else $error("print wait length");
  chk_hold_stays: assert property (
    hold_freeze && !run_key && !wr_en |=> hold_freeze)
    else $error("hold left early");
  chk_hold_cause: assert property (
    $rose(hold_freeze) |-> !pass_fail_output_oe && $past(rec_end, 2))
    else $error("hold without fail");
  cover property (srq_pulse);
  cover property (save_req);
  cover property ($rose(hold_freeze));
  cover property ($fell(print_busy));
endmodule
bind waveform_mask_judge waveform_mask_judge_props #(.PRINT_CNT(PRINT_CNT)) u_props (
  .clk(clk), .arst_n(arst_n), .rec_end(rec_end), .run_key(run_key), .wr_en(wr_en),
  .pass_fail_output_o(pass_fail_output_o), .pass_fail_output_oe(pass_fail_output_oe),
  .save_req(save_req), .print_busy(print_busy), .srq_pulse(srq_pulse),
  .hold_freeze(hold_freeze), .judging(judging));

/* bench/oc_receiver.sv */
`timescale 1ns/1ps
module oc_receiver (
  input wire pin_o,
  input wire pin_oe,
  output wire level
);
  // pull-up: a released pin reads high
  assign level = pin_oe ? pin_o : 1'b1;
endmodule

/* bench/waveform_mask_judge_tb.sv */
`timescale 1ns/1ps
`include "mask_judge_regs.vh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module waveform_mask_judge_tb;
  logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, smp_valid = 1'b0;
  logic [7:0] addr = 8'h0, s1 = 8'h0, s2 = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [8:0] smp_idx = 9'h0;
  logic [3:0] ch_shown = 4'h1;
  // 0 cw, 1 ccw, 2 up, 3 down, 4 left, 5 right, 6 run, 7 start, 8 end, 9 stored
  logic [9:0] pan = 10'h0;
  wire [31:0] rdata;
  wire pf_o, pf_oe, save_req, print_busy, srq_pulse, hold_freeze, judging, level;
  wire [3:0] acts = {print_busy, hold_freeze, save_req, srq_pulse};
  int bad_count = 0;
  int n_tests = 0;
  initial forever #2 clk = ~clk;
  waveform_mask_judge #(.CYCLE_CNT(32'd50), .PRINT_CNT(64'd20)) DUT (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rec_start(pan[7]), .rec_end(pan[8]), .smp_valid(smp_valid),
    .smp_idx(smp_idx), .channel_one_smp(s1), .channel_two_smp(s2),
    .channel_three_smp(8'h64), .channel_four_smp(8'h64), .ch_shown(ch_shown),
    .adjust_knob_cw(pan[0]), .adjust_knob_ccw(pan[1]), .key_up(pan[2]), .key_down(pan[3]),
    .key_left(pan[4]), .key_right(pan[5]), .run_key(pan[6]), .save_done(pan[9]),
    .pass_fail_output_o(pf_o), .pass_fail_output_oe(pf_oe), .save_req(save_req),
    .print_busy(print_busy), .srq_pulse(srq_pulse), .hold_freeze(hold_freeze),
    .judging(judging));
  oc_receiver far_end (.pin_o(pf_o), .pin_oe(pf_oe), .level(level));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // static on purpose: its index feeds a non-blocking write
  task pulse(int i, int n);
    repeat (n) begin
      @(posedge clk);
      pan[i] <= 1'b1;
      @(posedge clk);
      pan[i] <= 1'b0;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  // idx 0-3 are outside the window and always far off; the 60-cycle lead lets the gap end
  task automatic rec(logic [7:0] a, b, c, int n);
    tick(60);
    pulse(7, 1);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_idx <= i[8:0];
      s1 <= i < 4 ? 8'hc8 : i < 8 ? a : b;
      s2 <= c;
    end
    @(posedge clk);
    smp_valid <= 1'b0;
    pulse(8, 1);
    // one edge after the verdict state: request pulses still stand here
    tick(1);
    #1;
  endtask
  task automatic t_reset;
    `CHK("level", 1'b0, level)
    rd(`ADDR_CTRL, 32'h0);
    rd(`ADDR_EDIT, 32'h1000);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    wr(`ADDR_RANGE, 32'h0);
    rd(`ADDR_RANGE, 32'h01ff0000);
    $display("reset test done");
  endtask
  task automatic t_edit;
    rec(8'h64, 8'h64, 8'h64, 512);
    wr(`ADDR_EDIT, 32'h1008);
    tick(520);
    pulse(3, 1);
    pulse(0, 3);
    pulse(1, 1);
    pulse(4, 1);
    pulse(1, 1);
    rd(`ADDR_OFFS, 32'h01ff0002);
    wr(`ADDR_EDIT, 32'h1000);
    tick(520);
    wr(`ADDR_EDIT, 32'h1009);
    pulse(4, 1);
    pulse(0, 4);
    pulse(5, 1);
    pulse(1, 1);
    rd(`ADDR_RANGE, 32'h01ff0000);
    wr(`ADDR_EDIT, 32'h1001);
    rd(`ADDR_RANGE, 32'h01fe0004);
    $display("edit test done");
  endtask
  task automatic t_modes;
    logic [2:0] ex [4] = '{3'b011, 3'b010, 3'b101, 3'b100};
    logic [7:0] ra [3] = '{8'h64, 8'hc8, 8'h64};
    logic [7:0] rb [3] = '{8'hc8, 8'hc8, 8'h64};
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_CTRL, {29'h0, m[1:0], 1'b1});
      for (int r = 0; r < 3; r++) begin
        rec(ra[r], rb[r], 8'h64, 12);
        `CHK("verdict", ex[m][r], level)
      end
    end
    rd(`ADDR_COUNT, 32'h0006000c);
    $display("mode test done");
  endtask
  task automatic t_chan;
    logic [31:0] cc [4] = '{32'h9, 32'h1, 32'h21, 32'h21};
    logic [3:0] sh [4] = '{4'h1, 4'h1, 4'h1, 4'h3};
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CTRL, cc[k]);
      ch_shown <= sh[k];
      rec(8'h64, 8'h64, 8'hc8, 12);
      `CHK("channel", k == 0 || k == 3, level)
    end
    $display("channel test done");
  endtask
  task automatic t_act;
    logic [3:0] fx [5] = '{4'h0, 4'h4, 4'h2, 4'h8, 4'h1};
    int n;
    ch_shown <= 4'h1;
    for (int k = 0; k < 5; k++) begin
      wr(`ADDR_CTRL, {23'h0, k[2:0], 6'h1});
      rec(8'hc8, 8'hc8, 8'h64, 12);
      `CHK("actions", fx[k], acts)
      if (k == 1) begin
        rec(8'h64, 8'h64, 8'h64, 12);
        `CHK("held", 2'b11, {hold_freeze, level})
        pulse(6, 1);
        #1;
        `CHK("held", 1'b0, hold_freeze)
      end
      if (k == 2) pulse(9, 1);
      n = 0;
      while (print_busy === 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      `CHK("print", k == 3 ? 20 : 0, n)
    end
    wr(`ADDR_CTRL, 32'h0);
    tick(2);
    #1;
    `CHK("off", 2'b00, {judging, level})
    $display("action test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(40000);
    bad_count++;
    conclude();
  end
  initial begin
    tick(16);
    arst_n <= 1'b1;
    t_reset();
    t_edit();
    t_modes();
    t_chan();
    t_act();
    conclude();
  end
endmodule
